// ==== core/rcdo_cfg.svh ====
// constants for the reference clock divider output block
// assumes inclusion by every design file that decodes the control register
`ifndef RCDO_CFG_SVH
`define RCDO_CFG_SVH
`define RCDO_CTRL_OFFSET 12'h000
`define RCDO_STAT_OFFSET 12'h004
`define RCDO_CTRL_RESET 8'h30
`define RCDO_BIT_ENABLE 7
`define RCDO_BIT_PIN_OE 6
`define RCDO_BIT_SLEW 5
`define RCDO_DUTY_HI 4
`define RCDO_DUTY_LO 3
`define RCDO_DIV_HI 2
`define RCDO_DIV_LO 0
`define RCDO_DUTY_0 2'h0
`define RCDO_DUTY_25 2'h1
`define RCDO_DUTY_50 2'h2
`define RCDO_DUTY_75 2'h3
`define RCDO_DIV_1 3'h0
`define RCDO_DIV_2 3'h1
`define RCDO_CNT_W 7
`define RCDO_INSTR_DIV_W 2
`endif

// ==== core/rcdo_cfg_if.sv ====
// settings carried from the register file to the divider core
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface rcdo_cfg_if;
    logic enable;
    logic [1:0] duty;
    logic [2:0] div;
    logic phase_wrap;
    modport regs (output enable, output duty, output div, input phase_wrap);
    modport core (input enable, input duty, input div, output phase_wrap);
endinterface // rcdo_cfg_if

// ==== core/rcdo_div_core.sv ====
// divider and duty shaper producing the reference clock in the system clock domain
// assumes settings arrive through rcdo_cfg_if and change only at period boundaries
`timescale 1ns/10ps
`include "rcdo_cfg.svh"
module rcdo_div_core (
    input wire logic clk_i,
    input wire logic rst_i,
    rcdo_cfg_if.core cfg,
    output logic ref_clk_o
);
    import rcdo_pkg::*;
    logic [`RCDO_CNT_W-1:0] cnt_r;
    logic [`RCDO_CNT_W-1:0] mask;
    logic [`RCDO_CNT_W-1:0] quarter;
    logic [`RCDO_CNT_W:0] period;
    logic hi_nxt;
    logic ref_clk_r;
    // period minus one as a mask, all ones at the wrap
    assign mask = `RCDO_CNT_W'((`RCDO_CNT_W+1)'(1) << cfg.div) - `RCDO_CNT_W'(1);
    assign period = (`RCDO_CNT_W+1)'(1) << cfg.div;
    assign quarter = `RCDO_CNT_W'(period >> 2);
    assign cfg.phase_wrap = ((cnt_r & mask) == mask);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (!cfg.enable || cfg.phase_wrap) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + `RCDO_CNT_W'(1);
        end
    end
    // divide by two has no quarter step: 25 and 75 fall back to a half, set by the source clock
    always_comb begin
        hi_nxt = 1'b0;
        case (cfg.duty)
            `RCDO_DUTY_0: hi_nxt = 1'b0;
            `RCDO_DUTY_25: hi_nxt = (cfg.div == `RCDO_DIV_2) ? (cnt_r == '0) : (cnt_r < quarter);
            `RCDO_DUTY_50: hi_nxt = (cnt_r < (quarter << 1)) || (cfg.div == `RCDO_DIV_2 && cnt_r == '0);
            `RCDO_DUTY_75: hi_nxt = (cfg.div == `RCDO_DIV_2) ? (cnt_r == '0) : (cnt_r < (quarter * 3));
            default: hi_nxt = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_clk_r <= 1'b0;
        end else begin
            ref_clk_r <= cfg.enable && hi_nxt;
        end
    end
    // undivided: pass the source clock straight through, gated to zero at 0 percent
    assign ref_clk_o = (cfg.div == `RCDO_DIV_1) ? (cfg.enable && cfg.duty != `RCDO_DUTY_0 && clk_i)
                                                : ref_clk_r;
    a_zero_duty_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (cfg.duty == `RCDO_DUTY_0) |=> !ref_clk_r) else $error("ref clock high at zero duty");
    a_disabled_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg.enable |=> (cnt_r == '0 && !ref_clk_r)) else $error("divider ran while disabled");
endmodule // rcdo_div_core

// ==== core/rcdo_pkg.sv ====
// types for the reference clock divider output block
// assumes nothing beyond a SystemVerilog compiler
package rcdo_pkg;
    typedef enum logic [2:0] {
        RCDO_PIN_REF = 3'b001,
        RCDO_PIN_INSTR = 3'b010,
        RCDO_PIN_OSC = 3'b100
    } rcdo_pin_src_t;
endpackage

// ==== core/rcdo_top.sv ====
// reference clock divider output: APB register, divider core, pin mux
// assumes APB master on CLOCK_I, straps sampled from pins, sleep stops CLOCK_I upstream
`timescale 1ns/10ps
`include "rcdo_cfg.svh"
module rcdo_top (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic LOW_POWER_CRYSTAL_MODE_I,
    input wire logic STANDARD_CRYSTAL_MODE_I,
    input wire logic HIGH_SPEED_CRYSTAL_MODE_I,
    input wire logic INSTR_CLOCK_OUT_CONFIG_N_I,
    output logic DIVIDED_CLOCK_PIN_O,
    output logic DIVIDED_CLOCK_PIN_OE_O,
    output logic REF_PIN_SLEW_LIMIT_O,
    output logic MODULATOR_CLOCK_O,
    output rcdo_pkg::rcdo_pin_src_t PIN_SOURCE_O
);
    import rcdo_pkg::*;
    // named copy of the reset word so its fields can be sliced as constants
    localparam logic [7:0] CTRL_RST = `RCDO_CTRL_RESET;
    logic [7:0] ctrl_r;
    logic [1:0] duty_r;
    logic [2:0] div_r;
    logic [3:0] strap_s1_r;
    logic [3:0] strap_s2_r;
    logic [1:0] instr_cnt_r;
    logic ref_clk;
    logic crystal_mode;
    logic apb_wr;
    logic apb_hit;
    rcdo_pin_src_t pin_src_nxt;
    rcdo_cfg_if cfg_bus ();
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign apb_hit = (PADDR_I == `RCDO_CTRL_OFFSET) || (PADDR_I == `RCDO_STAT_OFFSET);
    // zero wait states; unmapped addresses answer with an error
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !apb_hit;
        end
    end
    // writes land when pready is seen high, the cycle the access completes
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ctrl_r <= `RCDO_CTRL_RESET;
        end else if (apb_wr && PREADY_O && PADDR_I == `RCDO_CTRL_OFFSET && PSTRB_I[0]) begin
            ctrl_r <= PWDATA_I[7:0];
        end
    end
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            if (PADDR_I == `RCDO_CTRL_OFFSET) begin
                PRDATA_O <= {24'h0, ctrl_r};
            end else if (PADDR_I == `RCDO_STAT_OFFSET) begin
                PRDATA_O <= {27'h0, duty_r, div_r};
            end else begin
                PRDATA_O <= 32'h0;
            end
        end
    end
    // shadow settings move only at a period wrap or while idle, so no runt pulse
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            duty_r <= CTRL_RST[`RCDO_DUTY_HI:`RCDO_DUTY_LO];
            div_r <= CTRL_RST[`RCDO_DIV_HI:`RCDO_DIV_LO];
        end else if (!ctrl_r[`RCDO_BIT_ENABLE] || cfg_bus.phase_wrap) begin
            duty_r <= ctrl_r[`RCDO_DUTY_HI:`RCDO_DUTY_LO];
            div_r <= ctrl_r[`RCDO_DIV_HI:`RCDO_DIV_LO];
        end
    end
    assign cfg_bus.enable = ctrl_r[`RCDO_BIT_ENABLE];
    assign cfg_bus.duty = duty_r;
    assign cfg_bus.div = div_r;
    rcdo_div_core u_core (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .cfg(cfg_bus),
        .ref_clk_o(ref_clk)
    );
    // straps come from pins: two flops before use
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            strap_s1_r <= 4'h0;
            strap_s2_r <= 4'h0;
        end else begin
            strap_s1_r <= {INSTR_CLOCK_OUT_CONFIG_N_I, HIGH_SPEED_CRYSTAL_MODE_I,
                           STANDARD_CRYSTAL_MODE_I, LOW_POWER_CRYSTAL_MODE_I};
            strap_s2_r <= strap_s1_r;
        end
    end
    // reset value 0 means clock-out active until the strap is seen high
    assign crystal_mode = |strap_s2_r[2:0];
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            instr_cnt_r <= 2'h0;
        end else begin
            instr_cnt_r <= instr_cnt_r + 2'h1;
        end
    end
    always_comb begin
        if (crystal_mode) begin
            pin_src_nxt = RCDO_PIN_OSC;
        end else if (!strap_s2_r[3]) begin
            pin_src_nxt = RCDO_PIN_INSTR;
        end else begin
            pin_src_nxt = RCDO_PIN_REF;
        end
    end
    // pin path is registered, so the undivided mode reaches the pin at half rate resolution;
    // the modulator output is registered the same way, one flop behind ref_clk
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            DIVIDED_CLOCK_PIN_O <= 1'b0;
            DIVIDED_CLOCK_PIN_OE_O <= 1'b0;
            REF_PIN_SLEW_LIMIT_O <= 1'b1;
            PIN_SOURCE_O <= RCDO_PIN_REF;
            MODULATOR_CLOCK_O <= 1'b0;
        end else begin
            PIN_SOURCE_O <= pin_src_nxt;
            REF_PIN_SLEW_LIMIT_O <= ctrl_r[`RCDO_BIT_SLEW];
            MODULATOR_CLOCK_O <= ref_clk;
            case (pin_src_nxt)
                RCDO_PIN_OSC: begin
                    DIVIDED_CLOCK_PIN_O <= 1'b0;
                    DIVIDED_CLOCK_PIN_OE_O <= 1'b0;
                end
                RCDO_PIN_INSTR: begin
                    DIVIDED_CLOCK_PIN_O <= instr_cnt_r[1];
                    DIVIDED_CLOCK_PIN_OE_O <= 1'b1;
                end
                RCDO_PIN_REF: begin
                    DIVIDED_CLOCK_PIN_O <= ctrl_r[`RCDO_BIT_PIN_OE] && ref_clk;
                    DIVIDED_CLOCK_PIN_OE_O <= ctrl_r[`RCDO_BIT_PIN_OE];
                end
                default: begin
                    DIVIDED_CLOCK_PIN_O <= 1'b0;
                    DIVIDED_CLOCK_PIN_OE_O <= 1'b0;
                end
            endcase
        end
    end
    // sleep is modelled by CLOCK_I stopping: every flop simply holds its level

    a_reset_default: assert property (@(posedge CLOCK_I) $fell(SYS_RST_I) |-> ctrl_r == `RCDO_CTRL_RESET)
        else $error("control not at default after reset");
    a_ctrl_write: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (apb_wr && PREADY_O && PADDR_I == `RCDO_CTRL_OFFSET && PSTRB_I[0]) |=> ctrl_r == $past(PWDATA_I[7:0]))
        else $error("control write lost");
    a_pin_off_oe: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (pin_src_nxt == RCDO_PIN_REF && !ctrl_r[`RCDO_BIT_PIN_OE]) |=> !DIVIDED_CLOCK_PIN_O && !DIVIDED_CLOCK_PIN_OE_O)
        else $error("pin driven without output enable");
    a_crystal_pin: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        crystal_mode |=> !DIVIDED_CLOCK_PIN_OE_O) else $error("pin driven in crystal mode");
    a_instr_clock: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (pin_src_nxt == RCDO_PIN_INSTR && $stable(pin_src_nxt)) |=> DIVIDED_CLOCK_PIN_O == $past(instr_cnt_r[1]))
        else $error("instruction clock not on pin");
    a_slew_follow: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        ##1 REF_PIN_SLEW_LIMIT_O == $past(ctrl_r[`RCDO_BIT_SLEW])) else $error("slew limit mismatch");
    a_modulator_feed: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (crystal_mode && div_r != `RCDO_DIV_1) |=> MODULATOR_CLOCK_O == $past(ref_clk))
        else $error("modulator not fed");
    a_shadow_hold: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        (ctrl_r[`RCDO_BIT_ENABLE] && !cfg_bus.phase_wrap) |=> $stable(div_r) && $stable(duty_r))
        else $error("divider changed mid period");
    c_ref_on_pin: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        pin_src_nxt == RCDO_PIN_REF && ctrl_r[`RCDO_BIT_PIN_OE] ##1 $rose(DIVIDED_CLOCK_PIN_O));
    c_div128: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        div_r == 3'h7 && cfg_bus.phase_wrap);
    c_instr_pin: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I) pin_src_nxt == RCDO_PIN_INSTR);
endmodule // rcdo_top

// ==== tb/rcdo_clk_sink.sv ====
// partner: an external device on the divided clock pin, measuring its high and low runs
// assumes the line is sampled on the system clock; a released line reads low
`timescale 1ns/10ps
module rcdo_clk_sink (
    input wire logic clk_i,
    input wire logic line_i,
    output int high_len_o,
    output int low_len_o
);
    logic prev_r;
    int run_r;
    // only completed runs are reported, so a half-seen phase never counts
    always_ff @(posedge clk_i) begin
        prev_r <= line_i;
        if (line_i === prev_r) begin
            run_r <= run_r + 1;
        end else begin
            run_r <= 1;
            if (prev_r === 1'b1) begin
                high_len_o <= run_r;
            end else begin
                low_len_o <= run_r;
            end
        end
    end
endmodule // rcdo_clk_sink

// ==== tb/rcdo_tb_top.sv ====
// testbench: apb register access, divider and duty table, pin conflicts, sleep and reset
// assumes rcdo_top with control at 12'h000 and status at 12'h004
`timescale 1ns/10ps
module rcdo_tb_top;
    import rcdo_pkg::*;
    typedef struct {logic [7:0] ctrl; int hi; int lo;} rcdo_row_t;
    logic CLOCK_I = 0;
    logic SYS_RST_I = 1;
    logic run_clk = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [2:0] xtal = 3'h0;
    logic instr_clock_out_function_n = 1;
    logic [31:0] prdata, rdv, pin_hi, mod_hi;
    logic pready, pslverr, pin, pin_oe, slew, mod_clk, erv, sl_pin, sl_mod;
    rcdo_pin_src_t pin_src;
    int errors = 0;
    int total_checks = 0;
    int hi_len, lo_len;
    // no keeper on the pin: a released line is taken as pulled low
    wire logic line = pin_oe ? pin : 1'b0;
    rcdo_row_t rows [12] = '{'{8'h31, 1, 1}, '{8'h29, 1, 1}, '{8'h39, 1, 1}, '{8'h2a, 1, 3},
        '{8'h3a, 3, 1}, '{8'h13, 4, 4}, '{8'h2c, 4, 12}, '{8'h3d, 24, 8}, '{8'h16, 32, 32},
        '{8'h2f, 32, 96}, '{8'h27, 0, 0}, '{8'h20, 0, 0}};

    always #10 if (run_clk) CLOCK_I = ~CLOCK_I;

    rcdo_top uut (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .LOW_POWER_CRYSTAL_MODE_I(xtal[0]),
        .STANDARD_CRYSTAL_MODE_I(xtal[1]), .HIGH_SPEED_CRYSTAL_MODE_I(xtal[2]),
        .INSTR_CLOCK_OUT_CONFIG_N_I(instr_clock_out_function_n), .DIVIDED_CLOCK_PIN_O(pin), .DIVIDED_CLOCK_PIN_OE_O(pin_oe),
        .REF_PIN_SLEW_LIMIT_O(slew), .MODULATOR_CLOCK_O(mod_clk), .PIN_SOURCE_O(pin_src));
    rcdo_clk_sink sink (.clk_i(CLOCK_I), .line_i(line), .high_len_o(hi_len), .low_len_o(lo_len));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge CLOCK_I);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge CLOCK_I);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK_I);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, d, e);
        chk("prdata", exp, d);
        chk("pslverr", {31'h0, eexp}, {31'h0, e});
    endtask
    task automatic wr(input logic [7:0] v);
        apb(1'b1, 12'h000, {24'h0, v}, 4'hf, rdv, erv);
    endtask
    // settles briefly, then counts high samples of pin and modulator clock
    task automatic watch(input int n);
        repeat (8) @(posedge CLOCK_I);
        pin_hi = 32'h0;
        mod_hi = 32'h0;
        repeat (n) begin
            @(posedge CLOCK_I);
            pin_hi = pin_hi + pin;
            mod_hi = mod_hi + mod_clk;
        end
    endtask
    task automatic summarize;
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge CLOCK_I);
        chk("slew_rst", 32'h1, slew);
        chk("oe_rst", 32'h0, pin_oe);
        chk("mod_rst", 32'h0, mod_clk);
        repeat (3) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b0;
        rd_chk(12'h000, 32'h30, 1'b0);
        rd_chk(12'h008, 32'h0, 1'b1);
        apb(1'b1, 12'h000, 32'h1f, 4'h0, rdv, erv);
        rd_chk(12'h000, 32'h30, 1'b0);
        foreach (rows[i]) begin
            wr(rows[i].ctrl);
            wr(rows[i].ctrl | 8'hc0);
            rd_chk(12'h000, {24'h0, rows[i].ctrl | 8'hc0}, 1'b0);
            repeat ((3 << rows[i].ctrl[2:0]) + 20) @(posedge CLOCK_I);
            chk("oe_on", 32'h1, pin_oe);
            chk("slew", rows[i].ctrl[5], slew);
            rd_chk(12'h004, {27'h0, rows[i].ctrl[4:0]}, 1'b0);
            if (rows[i].hi > 0) begin
                chk("high_len", rows[i].hi, hi_len);
                chk("low_len", rows[i].lo, lo_len);
            end else begin
                watch(300);
                chk("zero_pin", 32'h0, pin_hi);
                chk("zero_mod", 32'h0, mod_hi);
            end
        end
        wr(8'h72);
        watch(40);
        chk("off_pin", 32'h0, pin_hi);
        chk("off_mod", 32'h0, mod_hi);
        wr(8'hb2);
        watch(40);
        chk("oe_off", 32'h0, pin_oe);
        chk("oe_off_mod", 32'h14, mod_hi);
        wr(8'hf2);
        watch(40);
        chk("on_pin", 32'h14, pin_hi);
        chk("on_mod", 32'h14, mod_hi);
        for (int k = 0; k < 3; k++) begin
            xtal <= 3'h1 << k;
            watch(40);
            chk("osc_src", RCDO_PIN_OSC, pin_src);
            chk("osc_oe", 32'h0, pin_oe);
            chk("osc_mod", 32'h14, mod_hi);
        end
        xtal <= 3'h0;
        instr_clock_out_function_n <= 1'b0;
        watch(40);
        chk("instr_src", RCDO_PIN_INSTR, pin_src);
        chk("instr_pin", 32'h14, pin_hi);
        chk("instr_mod", 32'h14, mod_hi);
        instr_clock_out_function_n <= 1'b1;
        watch(3);
        run_clk = 1'b0;
        // let the last edge's updates settle before taking the held levels
        #1;
        sl_pin = pin;
        sl_mod = mod_clk;
        #500;
        chk("sleep_pin", sl_pin, pin);
        chk("sleep_mod", sl_mod, mod_clk);
        run_clk = 1'b1;
        @(posedge CLOCK_I);
        SYS_RST_I <= 1'b1;
        @(posedge CLOCK_I);
        chk("rst_oe", 32'h0, pin_oe);
        SYS_RST_I <= 1'b0;
        rd_chk(12'h000, 32'h30, 1'b0);
        summarize;
    end

    // the whole sequence needs well under ten thousand cycles
    initial begin
        #200000;
        errors++;
        summarize;
    end
endmodule // rcdo_tb_top
